// >>> design/cgtl_top.sv
// Clock generator tail: trim compare bytes, lock-loss response, modes
`timescale 1ns/1ps
`include "cgtl_regs.svh"

module cgtl_top
    import cgtl_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // Clock and reset
    input  logic              mclk,
    input  logic              rstn,
    // AXI4-Lite write address
    input  logic [ADDR_W-1:0] s_axi_awaddr,
    input  logic              s_axi_awvalid,
    output logic              s_axi_awready,
    // AXI4-Lite write data
    input  logic [31:0]       s_axi_wdata,
    input  logic [3:0]        s_axi_wstrb,
    input  logic              s_axi_wvalid,
    output logic              s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  logic              s_axi_bready,
    // AXI4-Lite read address
    input  logic [ADDR_W-1:0] s_axi_araddr,
    input  logic              s_axi_arvalid,
    output logic              s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  logic              s_axi_rready,
    // Events from the rest of the clock generator
    input  logic              lockLoss,
    input  logic              trimCtlWrite,
    input  cgtl_stop_t        stop,
    // Trim machine
    output logic [7:0]        trimCompareHigh,
    output logic [7:0]        trimCompareLow,
    output logic              trimEnable,
    // Clock state
    output cgtl_mode_t        mode,
    output logic [1:0]        clockSelect,
    output logic [1:0]        clockStatus,
    // Lock-loss requests
    output logic              lolIrqReq,
    output logic              lolResetReq
);

    if (ADDR_W < 8 || ADDR_W > 32) begin : gAddrCheck
        $error("ADDR_W must lie between 8 and 32");
    end

    localparam logic [7:0] LolRstVal = `CGTL_LOL_RST;

    logic [ADDR_W-1:0] awAddrQ;
    logic [31:0]       wDataQ;
    logic [3:0]        wStrbQ;
    logic              doWrite;
    logic [5:0]        wrIdx;
    logic              wrHit;
    logic              lane0;
    logic              lossSelect;
    logic              irqEnable;
    logic              pllStopKeep;
    logic [3:0]        modeRequest;
    logic              reqValid;
    logic              trimFail;
    logic              refusedFlag;
    logic              lockLossFlag;
    logic              refusedPulse;
    logic              trimFailSet;

    // Address decode; upper bits must be zero to hit a register
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [5:0] i;
        i = a[7:2];
        mapped = (a >> 8) == '0 &&
                 i >= `CGTL_IDX_TRIM_HIGH && i <= `CGTL_IDX_STATUS;
    endfunction

    function automatic logic reservedIdx(input logic [5:0] i);
        reservedIdx = i == `CGTL_IDX_CTL_SEVEN ||
                      i == `CGTL_IDX_CTL_NINE ||
                      i == `CGTL_IDX_CTL_TEN;
    endfunction

    assign wrIdx   = awAddrQ[7:2];
    assign wrHit   = mapped(awAddrQ);
    assign lane0   = wStrbQ[0];
    assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    // Write address and data are taken in either order
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            awAddrQ       <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awAddrQ       <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_wready <= 1'b1;
            wDataQ       <= 32'h0000_0000;
            wStrbQ       <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wDataQ       <= s_axi_wdata;
            wStrbQ       <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Response one cycle after both halves are held
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `CGTL_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? `CGTL_RESP_OKAY : `CGTL_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Trim compare bytes
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            trimCompareHigh <= `CGTL_TRIM_HIGH_RST;
        end else if (doWrite && wrHit && lane0 &&
                     wrIdx == `CGTL_IDX_TRIM_HIGH) begin
            trimCompareHigh <= wDataQ[7:0];
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            trimCompareLow <= `CGTL_TRIM_LOW_RST;
        end else if (doWrite && wrHit && lane0 &&
                     wrIdx == `CGTL_IDX_TRIM_LOW) begin
            trimCompareLow <= wDataQ[7:0];
        end
    end

    // Only the reset select bit is stored; the rest of the byte is tied
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lossSelect <= LolRstVal[`CGTL_LOL_SEL_BIT];
        end else if (doWrite && wrHit && lane0 &&
                     wrIdx == `CGTL_IDX_LOCK_LOSS) begin
            lossSelect <= wDataQ[`CGTL_LOL_SEL_BIT];
        end
    end

    // Mode control; a write here also issues a mode request
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            modeRequest <= 4'h0;
            irqEnable   <= 1'b0;
            pllStopKeep <= 1'b0;
            trimEnable  <= 1'b0;
            reqValid    <= 1'b0;
        end else begin
            reqValid <= 1'b0;
            if (doWrite && wrHit && lane0 &&
                wrIdx == `CGTL_IDX_MODE_CTL) begin
                modeRequest <= wDataQ[`CGTL_CTL_REQ_LSB +: 4];
                irqEnable   <= wDataQ[`CGTL_CTL_IRQEN_BIT];
                pllStopKeep <= wDataQ[`CGTL_CTL_KEEP_BIT];
                trimEnable  <= wDataQ[`CGTL_CTL_TRIMEN_BIT];
                reqValid    <= 1'b1;
            end
        end
    end

    // Set sources for the trim fail flag
    assign trimFailSet = trimEnable && (stop.enter || trimCtlWrite ||
                         (doWrite && wrHit &&
                          wrIdx == `CGTL_IDX_MODE_CTL));

    // Sticky flags; a set in the same cycle as a clear wins
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            trimFail <= 1'b0;
        end else if (trimFailSet) begin
            trimFail <= 1'b1;
        end else if (doWrite && wrHit && wrIdx == `CGTL_IDX_STATUS) begin
            trimFail <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            refusedFlag <= 1'b0;
        end else if (refusedPulse) begin
            refusedFlag <= 1'b1;
        end else if (doWrite && wrHit && wStrbQ[0] &&
                     wrIdx == `CGTL_IDX_STATUS &&
                     wDataQ[`CGTL_STS_REFUSE_BIT]) begin
            refusedFlag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lockLossFlag <= 1'b0;
        end else if (lockLoss) begin
            lockLossFlag <= 1'b1;
        end else if (doWrite && wrHit && wStrbQ[1] &&
                     wrIdx == `CGTL_IDX_STATUS &&
                     wDataQ[`CGTL_STS_LOL_BIT]) begin
            lockLossFlag <= 1'b0;
        end
    end

    // Read path: one read at a time, data one cycle after the address
    function automatic logic [31:0] readMux(input logic [ADDR_W-1:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (mapped(a)) begin
            case (a[7:2])
                `CGTL_IDX_TRIM_HIGH: d[7:0] = trimCompareHigh;
                `CGTL_IDX_TRIM_LOW:  d[7:0] = trimCompareLow;
                `CGTL_IDX_LOCK_LOSS: d[`CGTL_LOL_SEL_BIT] = lossSelect;
                `CGTL_IDX_MODE_CTL: begin
                    d[`CGTL_CTL_REQ_LSB +: 4]  = modeRequest;
                    d[`CGTL_CTL_IRQEN_BIT]     = irqEnable;
                    d[`CGTL_CTL_KEEP_BIT]      = pllStopKeep;
                    d[`CGTL_CTL_TRIMEN_BIT]    = trimEnable;
                end
                `CGTL_IDX_STATUS: begin
                    d[`CGTL_STS_CST_LSB +: 2]  = clockStatus;
                    d[`CGTL_STS_MODE_LSB +: 4] = mode;
                    d[`CGTL_STS_TFAIL_BIT]     = trimFail;
                    d[`CGTL_STS_REFUSE_BIT]    = refusedFlag;
                    d[`CGTL_STS_LOL_BIT]       = lockLossFlag;
                end
                default: d = 32'h0000_0000;
            endcase
        end
        return d;
    endfunction

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `CGTL_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= readMux(s_axi_araddr);
            s_axi_rresp   <= mapped(s_axi_araddr) ? `CGTL_RESP_OKAY
                                                  : `CGTL_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    cgtl_mode_fsm uModeFsm (
        .mclk        (mclk),
        .rstn        (rstn),
        .reqValid    (reqValid),
        .reqMode     (cgtl_mode_t'(modeRequest)),
        .pllStopKeep (pllStopKeep),
        .stop        (stop),
        .mode        (mode),
        .clockSelect (clockSelect),
        .clockStatus (clockStatus),
        .refused     (refusedPulse)
    );

    cgtl_lock_loss uLockLoss (
        .mclk        (mclk),
        .rstn        (rstn),
        .lockLoss    (lockLoss),
        .resetSelect (lossSelect),
        .irqEnable   (irqEnable),
        .irqReq      (lolIrqReq),
        .resetReq    (lolResetReq)
    );

    sequence highWrite_s;
        doWrite && wrHit && lane0 && wrIdx == `CGTL_IDX_TRIM_HIGH;
    endsequence

    sequence lowWrite_s;
        doWrite && wrHit && lane0 && wrIdx == `CGTL_IDX_TRIM_LOW;
    endsequence

    trim_high_a: assert property (@(posedge mclk) disable iff (!rstn)
        highWrite_s |=> trimCompareHigh == $past(wDataQ[7:0]) &&
        s_axi_bvalid)
        else $error("trim compare high not updated");

    trim_low_a: assert property (@(posedge mclk) disable iff (!rstn)
        lowWrite_s |=> trimCompareLow == $past(wDataQ[7:0]) &&
        s_axi_bvalid)
        else $error("trim compare low not updated");

    rsvd_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
        s_axi_arvalid && s_axi_arready && (s_axi_araddr >> 8) == '0 &&
        reservedIdx(s_axi_araddr[7:2])
        |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
        else $error("reserved register read not zero");

    lol_rsvd_a: assert property (@(posedge mclk) disable iff (!rstn)
        s_axi_arvalid && s_axi_arready && (s_axi_araddr >> 8) == '0 &&
        s_axi_araddr[7:2] == `CGTL_IDX_LOCK_LOSS
        |=> s_axi_rdata[31:7] == '0 && s_axi_rdata[5:0] == '0 &&
        s_axi_rdata[6] == lossSelect)
        else $error("lock-loss reserved bits not zero");

    tfail_set_a: assert property (@(posedge mclk) disable iff (!rstn)
        trimEnable && (stop.enter || trimCtlWrite) |=> trimFail)
        else $error("trim fail flag not set");

    tfail_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
        doWrite && wrHit && wrIdx == `CGTL_IDX_STATUS && !trimFailSet
        |=> !trimFail)
        else $error("trim fail flag not cleared");

endmodule // cgtl_top

// >>> design/cgtl_regs.svh
// Register indices, field positions, reset values and codes of the block
`ifndef CGTL_REGS_SVH
`define CGTL_REGS_SVH

// Word indices; byte address is four times the index
`define CGTL_IDX_TRIM_HIGH   6'h0A
`define CGTL_IDX_TRIM_LOW    6'h0B
`define CGTL_IDX_CTL_SEVEN   6'h0C
`define CGTL_IDX_LOCK_LOSS   6'h0D
`define CGTL_IDX_CTL_NINE    6'h0E
`define CGTL_IDX_CTL_TEN     6'h0F
`define CGTL_IDX_MODE_CTL    6'h10
`define CGTL_IDX_STATUS      6'h11

// Lock-loss control field
`define CGTL_LOL_SEL_BIT     6
// Mode control fields
`define CGTL_CTL_REQ_LSB     0
`define CGTL_CTL_IRQEN_BIT   4
`define CGTL_CTL_KEEP_BIT    5
`define CGTL_CTL_TRIMEN_BIT  6
// Status fields
`define CGTL_STS_CST_LSB     0
`define CGTL_STS_MODE_LSB    2
`define CGTL_STS_TFAIL_BIT   6
`define CGTL_STS_REFUSE_BIT  7
`define CGTL_STS_LOL_BIT     8

// Reset values
`define CGTL_TRIM_HIGH_RST   8'h00
`define CGTL_TRIM_LOW_RST    8'h00
`define CGTL_LOL_RST         8'h00

// Clock source select codes
`define CGTL_CLOCK_SOURCE_SELECT_LOOP       2'h0
`define CGTL_CLOCK_SOURCE_SELECT_INT        2'h1
`define CGTL_CLOCK_SOURCE_SELECT_EXT        2'h2

// Bus response codes
`define CGTL_RESP_OKAY       2'h0
`define CGTL_RESP_SLVERR     2'h2

`endif

// >>> design/cgtl_pkg.sv
// Types shared by the clock generator tail block
package cgtl_pkg;

    // Clock modes, Gray coded along the usual path
    typedef enum logic [3:0] {
        CGTL_FEI  = 4'h0,
        CGTL_FEE  = 4'h1,
        CGTL_FBE  = 4'h3,
        CGTL_PBE  = 4'h2,
        CGTL_PEE  = 4'h6,
        CGTL_BLPE = 4'h7,
        CGTL_FBI  = 4'h5,
        CGTL_BLPI = 4'h4,
        CGTL_STOP = 4'hC
    } cgtl_mode_t;

    // Stop-mode events from the power controller
    typedef struct packed {
        logic enter;
        logic lowLeak;
        logic exit;
    } cgtl_stop_t;

    // Permitted software-driven mode moves
    function automatic logic cgtl_permitted(input cgtl_mode_t from,
                                            input cgtl_mode_t to);
        logic ok;
        ok = 1'b0;
        case (from)
            CGTL_FEI:  ok = (to == CGTL_FEE) || (to == CGTL_FBI) ||
                            (to == CGTL_FBE);
            CGTL_FEE:  ok = (to == CGTL_FEI) || (to == CGTL_FBI) ||
                            (to == CGTL_FBE);
            CGTL_FBI:  ok = (to == CGTL_FEI) || (to == CGTL_FEE) ||
                            (to == CGTL_FBE) || (to == CGTL_BLPI);
            CGTL_FBE:  ok = (to == CGTL_FEI) || (to == CGTL_FEE) ||
                            (to == CGTL_FBI) || (to == CGTL_BLPE) ||
                            (to == CGTL_PBE);
            CGTL_PBE:  ok = (to == CGTL_FBE) || (to == CGTL_PEE) ||
                            (to == CGTL_BLPE);
            CGTL_PEE:  ok = (to == CGTL_PBE);
            CGTL_BLPI: ok = (to == CGTL_FBI);
            CGTL_BLPE: ok = (to == CGTL_FBE) || (to == CGTL_PBE);
            default:   ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Clock source select that belongs to each mode
    function automatic logic [1:0] cgtl_select(input cgtl_mode_t m);
        logic [1:0] s;
        s = 2'h0;
        case (m)
            CGTL_FBI, CGTL_BLPI:           s = 2'h1;
            CGTL_FBE, CGTL_PBE, CGTL_BLPE: s = 2'h2;
            default:                       s = 2'h0;
        endcase
        return s;
    endfunction

endpackage

// >>> design/cgtl_lock_loss.sv
// Loss-of-lock response: interrupt request or reset request
`timescale 1ns/1ps
`include "cgtl_regs.svh"

module cgtl_lock_loss
    import cgtl_pkg::*;
(
    // Clock and reset
    input  logic mclk,
    input  logic rstn,
    // Event and controls
    input  logic lockLoss,
    input  logic resetSelect,
    input  logic irqEnable,
    // Requests
    output logic irqReq,
    output logic resetReq
);

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irqReq <= 1'b0;
        end else begin
            irqReq <= lockLoss && !resetSelect && irqEnable;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            resetReq <= 1'b0;
        end else begin
            resetReq <= lockLoss && resetSelect;
        end
    end

    sequence lossWithIrq_s;
        lockLoss && !resetSelect && irqEnable;
    endsequence

    lol_irq_a: assert property (@(posedge mclk) disable iff (!rstn)
        lossWithIrq_s |=> irqReq && !resetReq)
        else $error("lock loss did not raise interrupt request");

    lol_irq_gated_a: assert property (@(posedge mclk) disable iff (!rstn)
        !(lockLoss && irqEnable && !resetSelect) |=> !irqReq)
        else $error("interrupt request without enabled lock loss");

    lol_reset_a: assert property (@(posedge mclk) disable iff (!rstn)
        lockLoss && resetSelect |=> resetReq && !irqReq)
        else $error("lock loss did not raise reset request");

endmodule // cgtl_lock_loss

// >>> design/cgtl_mode_fsm.sv
// Nine-mode clock state machine with stop-mode fallback
`timescale 1ns/1ps
`include "cgtl_regs.svh"

module cgtl_mode_fsm
    import cgtl_pkg::*;
(
    // Clock and reset
    input  logic       mclk,
    input  logic       rstn,
    // Software request
    input  logic       reqValid,
    input  cgtl_mode_t reqMode,
    input  logic       pllStopKeep,
    // Stop events
    input  cgtl_stop_t stop,
    // State
    output cgtl_mode_t mode,
    output logic [1:0] clockSelect,
    output logic [1:0] clockStatus,
    output logic       refused
);

    cgtl_mode_t savedMode;
    logic       stopLowLeak;
    logic       toStop;
    logic       fromStop;
    logic       enterFallback;
    logic       exitFallback;

    assign toStop        = stop.enter && (mode != CGTL_STOP);
    assign fromStop      = stop.exit && (mode == CGTL_STOP);
    assign enterFallback = toStop && (mode == CGTL_PEE) &&
                           !stop.lowLeak && !pllStopKeep;
    assign exitFallback  = fromStop && stopLowLeak &&
                           (savedMode == CGTL_PEE);

    // Stop events win over a software request in the same cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode        <= CGTL_FEI;
            savedMode   <= CGTL_FEI;
            stopLowLeak <= 1'b0;
            clockSelect <= `CGTL_CLOCK_SOURCE_SELECT_LOOP;
            refused     <= 1'b0;
        end else begin
            refused <= 1'b0;
            if (toStop) begin
                mode        <= CGTL_STOP;
                stopLowLeak <= stop.lowLeak;
                if (enterFallback) begin
                    savedMode   <= CGTL_PBE;
                    clockSelect <= `CGTL_CLOCK_SOURCE_SELECT_EXT;
                end else begin
                    savedMode <= mode;
                end
            end else if (fromStop) begin
                if (exitFallback) begin
                    mode        <= CGTL_PBE;
                    clockSelect <= `CGTL_CLOCK_SOURCE_SELECT_EXT;
                end else begin
                    mode        <= savedMode;
                    clockSelect <= cgtl_select(savedMode);
                end
            end else if (reqValid) begin
                if (cgtl_permitted(mode, reqMode)) begin
                    mode        <= reqMode;
                    clockSelect <= cgtl_select(reqMode);
                end else begin
                    refused <= 1'b1;
                end
            end
        end
    end

    // Status follows select a cycle later, except when forced
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            clockStatus <= `CGTL_CLOCK_SOURCE_SELECT_LOOP;
        end else if (enterFallback || exitFallback) begin
            clockStatus <= `CGTL_CLOCK_SOURCE_SELECT_EXT;
        end else begin
            clockStatus <= clockSelect;
        end
    end

    sequence badRequest_s;
        reqValid && !stop.enter && !stop.exit &&
        !cgtl_permitted(mode, reqMode);
    endsequence

    sequence lowLeakExitPee_s;
        mode == CGTL_STOP && stopLowLeak && savedMode == CGTL_PEE &&
        stop.exit;
    endsequence

    sequence normalStopPee_s;
        mode == CGTL_PEE && stop.enter && !stop.lowLeak && !pllStopKeep;
    endsequence

    mode_refuse_a: assert property (@(posedge mclk) disable iff (!rstn)
        badRequest_s |=> refused && $stable(mode))
        else $error("illegal mode move not refused");

    mode_move_a: assert property (@(posedge mclk) disable iff (!rstn)
        $changed(mode) && mode != CGTL_STOP && $past(mode) != CGTL_STOP
        |-> cgtl_permitted(cgtl_mode_t'($past(mode)), mode))
        else $error("mode moved along a forbidden path");

    exit_fallback_a: assert property (@(posedge mclk) disable iff (!rstn)
        lowLeakExitPee_s |=> mode == CGTL_PBE &&
        clockSelect == `CGTL_CLOCK_SOURCE_SELECT_EXT && clockStatus == `CGTL_CLOCK_SOURCE_SELECT_EXT)
        else $error("no fallback on low-leakage stop exit");

    stop_fallback_a: assert property (@(posedge mclk) disable iff (!rstn)
        normalStopPee_s |=> mode == CGTL_STOP &&
        clockSelect == `CGTL_CLOCK_SOURCE_SELECT_EXT && clockStatus == `CGTL_CLOCK_SOURCE_SELECT_EXT)
        else $error("no fallback on normal stop entry");

endmodule // cgtl_mode_fsm

// >>> sim/tb_cgtl_top.sv
// Bench for the clock generator tail block
`timescale 1ns/1ps
module tb_cgtl_top import cgtl_pkg::*; ;
    logic        mclk = 0, rstn = 0, awV, awR, wV, wR, bV, arV, arR, rV;
    logic        lockLoss, irq, rReq, tcw, te;
    logic [7:0]  awA, arA, hi, lo;
    logic [31:0] wD, rD;
    logic [1:0]  bResp, rResp, cSel, cSt;
    cgtl_stop_t  stop;
    cgtl_mode_t  mode;
    int          n_mismatch = 0, samples_checked = 0;
    always #12.5 mclk = ~mclk;
    // Ready held high, so every answer is taken when it appears
    cgtl_top i_dut (.mclk, .rstn, .s_axi_awaddr(awA), .s_axi_awvalid(awV),
        .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bResp),
        .s_axi_bvalid(bV), .s_axi_bready(1'b1), .s_axi_araddr(arA),
        .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD),
        .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(1'b1),
        .lockLoss, .trimCtlWrite(tcw), .stop, .trimCompareHigh(hi),
        .trimCompareLow(lo), .trimEnable(te), .mode, .clockSelect(cSel),
        .clockStatus(cSt), .lolIrqReq(irq), .lolResetReq(rReq));
    task automatic chk(input logic [31:0] g, e);
        samples_checked++;
        if (g !== e) n_mismatch++;
        if (g !== e) $display("wrong value at %0t: %h not %h", $time, g, e);
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [1:0] e);
        logic       f = 0;
        logic [2:0] next_v;
        if (w) {awA, wD, awV, wV} <= {a, d, 2'b11};
        else {arA, arV} <= {a, 1'b1};
        for (int n = 0; !f; n++) begin
            if (n > 40) begin n_mismatch++; print_verdict(); end
            @(negedge mclk);
            next_v = {awV & ~awR, wV & ~wR, arV & ~arR};
            f = w ? bV : rV;
            if (f) chk(32'(w ? bResp : rResp), 32'(e));
            if (f && !w) chk(rD, d);
            @(posedge mclk);
            // Last pass leaves the strobes alone for the next call
            if (!f) {awV, wV, arV} <= next_v;
        end
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic md(int k, cgtl_mode_t m, logic [1:0] s);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
        chk(32'({mode, cSel, cSt}), 32'({m, s, s}));
        @(posedge mclk);
    endtask
    // Exit follows entry at once, the tightest case for the saved mode
    task automatic sp(logic ll);
        stop <= {1'b1, ll, 1'b0};
        @(posedge mclk);
        stop <= 3'b001;
        @(negedge mclk);
        chk(32'(mode), 32'(CGTL_STOP));
        if (!ll) chk(32'({cSel, cSt}), 32'ha);
        @(posedge mclk);
        stop <= 3'b000;
        md(0, CGTL_PBE, 2'h2);
    endtask
    task automatic lol(logic ei, logic er);
        lockLoss <= 1;
        @(posedge mclk);
        lockLoss <= 0;
        @(negedge mclk);
        chk(32'({irq, rReq}), 32'({ei, er}));
        @(posedge mclk);
    endtask
    task automatic t_regs();
        bus(0, 8'h2c, 0, 0);
        bus(1, 8'h28, 32'h1a5, 0);
        bus(0, 8'h28, 32'ha5, 0);
        chk(32'(hi), 32'ha5);
        bus(1, 8'h2c, 32'h3c, 0);
        chk(32'(lo), 32'h3c);
        bus(1, 8'h34, 32'hffff_ffff, 0);
        bus(0, 8'h34, 32'h40, 0);
        bus(0, 8'h30, 0, 0);
        bus(1, 8'h38, 32'hff, 0);
        bus(0, 8'h38, 0, 0);
        bus(1, 8'h80, 0, 2'h2);
        bus(0, 8'h80, 0, 2'h2);
        lol(0, 1);
        bus(1, 8'h34, 0, 0);
        lol(0, 0);
        bus(1, 8'h40, 32'h13, 0);
        lol(1, 0);
    endtask
    // Trim enable set by the mode write itself, so that write sets no fail
    task automatic t_trim();
        bus(1, 8'h40, 32'h46, 0);
        chk(32'(te), 32'h1);
        tcw <= 1;
        @(posedge mclk);
        tcw <= 0;
        bus(0, 8'h44, 32'h1d8, 0);
        bus(1, 8'h44, 0, 0);
        bus(0, 8'h44, 32'h198, 0);
    endtask
    task automatic t_modes();
        bus(1, 8'h40, 32'h2, 0);
        bus(1, 8'h40, 0, 0);
        md(2, CGTL_PBE, 2'h2);
        bus(0, 8'h44, 32'h18a, 0);
        bus(1, 8'h40, 32'h6, 0);
        sp(0);
        bus(1, 8'h40, 32'h6, 0);
        sp(1);
    endtask
    initial begin
        {awV, wV, arV, lockLoss, tcw, awA, arA, wD, stop} = 0;
        repeat (6) @(posedge mclk);
        rstn <= 1;
        t_regs();
        t_modes();
        t_trim();
        print_verdict();
    end
endmodule // tb_cgtl_top
